//--- strap_pkg.sv
// package: strap pin map, register map, field layout and timing for the strap option sampler
package strap_pkg;

  // strap pin indices on the shared pin vector
  localparam int STATION_ADDR_BIT0_STRAP_IDX = 0;
  localparam int STATION_ADDR_BIT4_STRAP_IDX = 4;
  localparam int NEGOTIATION_ENABLE_STRAP_IDX = 5;
  localparam int CAPABILITY_SELECT_HIGH_STRAP_IDX = 6;
  localparam int CAPABILITY_SELECT_LOW_STRAP_IDX = 7;
  localparam int STRAP_PIN_COUNT = 8;

  // idle level of each pin as set by its internal weak pull
  // bit0 pulled up, address bits 4:1 pulled down, negotiation and capability pins pulled up
  localparam logic [7:0] STRAP_PULL_DEFAULT = 8'he1;

  // settle time after reset release before the pins are latched
  localparam int CORE_CLK_PERIOD_NS = 5;
  localparam int STRAP_SETTLE_NS = 20;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam logic [2:0] SETTLE_LOAD = 3'(STRAP_SETTLE_CYC - 1);

  // register map, byte addresses
  localparam logic [3:0] TRANSCEIVER_CONTROL_REGISTER_OFS = 4'h0;
  localparam logic [3:0] STRAP_STATUS_OFS = 4'h4;

  // transceiver control register fields
  localparam int CTRL_ADDR_LSB = 0;
  localparam logic [4:0] CTRL_ADDR_RESET = 5'h00;

  // strap status register fields
  localparam int STAT_ADDR_LSB = 0;
  localparam int STAT_ISOLATE_BIT = 5;
  localparam int STAT_NEG_EN_BIT = 6;
  localparam int STAT_CAP_LSB = 7;
  localparam int STAT_VALID_BIT = 9;

  // axi response codes
  localparam logic [1:0] AXI_RESP_OKAY = 2'b00;
  localparam logic [1:0] AXI_RESP_SLVERR = 2'b10;

  // advertised ability bits {100 full, 100 half, 10 full, 10 half}
  localparam logic [3:0] ADV_10_HALF_FULL = 4'h3;
  localparam logic [3:0] ADV_100_HALF_FULL = 4'hc;
  localparam logic [3:0] ADV_10_HALF = 4'h1;
  localparam logic [3:0] ADV_10_100_HALF = 4'h5;

  // latched strap configuration
  typedef struct packed {
    logic neg_en;
    logic [1:0] cap;
    logic [4:0] addr;
  } strap_cfg_t;

  localparam strap_cfg_t STRAP_CFG_RESET = '{neg_en: 1'b0, cap: 2'b00, addr: 5'h00};

  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_RUN = 2'b01
  } strap_state_t;

endpackage : strap_pkg

//--- strap_sync_bit.sv
// file: two flip-flop synchroniser for one pin, resetting to the pin's pull level
`timescale 1ns/1ps
module strap_sync_bit #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_core_clk, // core clock
  input wire logic i_rst, // async reset, active high
  input wire logic i_pin, // raw pin level
  output logic o_sync // synchronised level
);

  logic meta_ff;
  logic sync_ff;

  // first stage feeds only the second stage; reset value mirrors the weak pull
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= i_pin;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule : strap_sync_bit

//--- strap_option_sampler.sv
// file: strap option sampler with axi4-lite register access
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// How it works
// - pin levels held during reset are captured and select the starting configuration
// - after release and capture the pins are driven with their normal functions
// - five strapped address bits load the control register address field
// - every address value from 0 to 31 is accepted
// - a strapped address of zero puts the interface in isolate mode
// - writing zero to the address field later never causes isolate
// - unstrapped, address bit0 reads one, bits 4:1 read zero
// - negotiation strap high runs negotiation advertising the capability bits
// - negotiation strap low forces speed and duplex from the capability bits
module strap_option_sampler
  import strap_pkg::*;
(
  input wire logic i_core_clk, // core clock, 200 MHz
  input wire logic i_rst, // async reset, active high
  input wire logic [7:0] i_strap_pin_in, // level seen on the shared pins
  input wire logic [7:0] i_func_pin_out, // normal output value for each shared pin
  output logic [7:0] o_strap_pin_out, // value driven on the shared pins
  output logic [7:0] o_strap_pin_oe_n, // pin drive enable, low drives
  output logic [4:0] o_station_addr, // management station address
  output logic o_isolate, // interface isolate mode
  output logic o_negotiation_enable, // run auto-negotiation
  output logic [3:0] o_advert, // advertised abilities
  output logic o_forced_speed_100, // forced mode speed is 100
  output logic o_forced_full_duplex, // forced mode is full duplex
  output logic o_config_valid, // straps have been latched
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  strap_state_t state_ff;
  logic [2:0] settle_cnt_ff;
  logic [7:0] pin_sync;
  logic latch_pulse;
  strap_cfg_t strap_cfg_ff;
  logic [4:0] ctrl_addr_ff;
  logic [7:0] pin_out_ff;
  logic [7:0] pin_oe_n_ff;
  logic isolate_ff;
  logic neg_en_ff;
  logic [3:0] advert_ff;
  logic forced_100_ff;
  logic forced_full_ff;
  logic valid_ff;
  logic [3:0] nxt_advert;
  // axi state
  logic awready_ff;
  logic wready_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic do_write;
  logic [31:0] rd_word;
  logic [1:0] rd_resp;

  // pins arrive from the board, so each passes two flops; pull levels seed the chain
  genvar gi;
  generate
    for (gi = 0; gi < STRAP_PIN_COUNT; gi = gi + 1) begin : g_sync
      strap_sync_bit #(
        .RST_VAL(STRAP_PULL_DEFAULT[gi])
      ) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_pin(i_strap_pin_in[gi]),
        .o_sync(pin_sync[gi])
      );
    end
  endgenerate

  // pins stay released through reset and the settle window so the straps can be read
  assign latch_pulse = (state_ff == ST_SAMPLE) && (settle_cnt_ff == 3'h0);

  // sequencer: sample until the synchronisers hold post-reset levels, then run
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ST_SAMPLE;
      settle_cnt_ff <= SETTLE_LOAD;
    end else begin
      case (state_ff)
        ST_SAMPLE: begin
          if (settle_cnt_ff == 3'h0) begin
            state_ff <= ST_RUN;
          end else begin
            settle_cnt_ff <= settle_cnt_ff - 3'h1;
          end
        end
        ST_RUN: begin
          state_ff <= ST_RUN;
        end
        default: begin
          state_ff <= ST_SAMPLE;
          settle_cnt_ff <= SETTLE_LOAD;
        end
      endcase
    end
  end

  // strap capture, all 32 address values taken as-is
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_cfg_ff <= STRAP_CFG_RESET;
      valid_ff <= 1'b0;
    end else if (latch_pulse) begin
      strap_cfg_ff.addr <= pin_sync[STATION_ADDR_BIT4_STRAP_IDX:STATION_ADDR_BIT0_STRAP_IDX];
      strap_cfg_ff.neg_en <= pin_sync[NEGOTIATION_ENABLE_STRAP_IDX];
      strap_cfg_ff.cap <= {pin_sync[CAPABILITY_SELECT_HIGH_STRAP_IDX],
                           pin_sync[CAPABILITY_SELECT_LOW_STRAP_IDX]};
      valid_ff <= 1'b1;
    end
  end

  // pin drivers: released while sampling, normal function once latched
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_oe_n_ff <= 8'hff;
      pin_out_ff <= 8'h00;
    end else begin
      pin_out_ff <= i_func_pin_out;
      if (latch_pulse) begin
        pin_oe_n_ff <= 8'h00;
      end
    end
  end

  // advertisement lookup for negotiation mode
  always_comb begin
    case ({pin_sync[CAPABILITY_SELECT_HIGH_STRAP_IDX], pin_sync[CAPABILITY_SELECT_LOW_STRAP_IDX]})
      2'b00: nxt_advert = ADV_10_HALF_FULL;
      2'b01: nxt_advert = ADV_100_HALF_FULL;
      2'b10: nxt_advert = ADV_10_HALF;
      default: nxt_advert = ADV_10_100_HALF;
    endcase
  end

  // operating mode outputs, set once from the straps
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      isolate_ff <= 1'b0;
      neg_en_ff <= 1'b0;
      advert_ff <= 4'h0;
      forced_100_ff <= 1'b0;
      forced_full_ff <= 1'b0;
    end else if (latch_pulse) begin
      // isolate only follows the strap; register writes never reach it
      isolate_ff <= (pin_sync[STATION_ADDR_BIT4_STRAP_IDX:STATION_ADDR_BIT0_STRAP_IDX] == 5'h00);
      neg_en_ff <= pin_sync[NEGOTIATION_ENABLE_STRAP_IDX];
      if (pin_sync[NEGOTIATION_ENABLE_STRAP_IDX]) begin
        advert_ff <= nxt_advert;
        forced_100_ff <= 1'b0;
        forced_full_ff <= 1'b0;
      end else begin
        advert_ff <= 4'h0;
        forced_100_ff <= pin_sync[CAPABILITY_SELECT_HIGH_STRAP_IDX];
        forced_full_ff <= pin_sync[CAPABILITY_SELECT_LOW_STRAP_IDX];
      end
    end
  end

  // control register address field: strap load wins over a same-cycle write
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_addr_ff <= CTRL_ADDR_RESET;
    end else if (latch_pulse) begin
      ctrl_addr_ff <= pin_sync[STATION_ADDR_BIT4_STRAP_IDX:STATION_ADDR_BIT0_STRAP_IDX];
    end else if (do_write && awaddr_ff == TRANSCEIVER_CONTROL_REGISTER_OFS && wstrb_ff[0]) begin
      ctrl_addr_ff <= wdata_ff[CTRL_ADDR_LSB +: 5];
    end
  end

  // axi write: address and data taken in either order, response after both
  assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= AXI_RESP_OKAY;
    end else begin
      if (awready_ff && s_axi_awvalid) begin
        awready_ff <= 1'b0;
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr[3:0];
      end
      if (wready_ff && s_axi_wvalid) begin
        wready_ff <= 1'b0;
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        bvalid_ff <= 1'b1;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        // status is read-only and ignores writes; any other offset is unmapped, upper write address bits are not decoded
        bresp_ff <= (awaddr_ff == TRANSCEIVER_CONTROL_REGISTER_OFS || awaddr_ff == STRAP_STATUS_OFS)
                    ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // read mux; upper address bits must be zero to hit a register
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = AXI_RESP_OKAY;
    if (s_axi_araddr[31:4] != 28'h0) begin
      rd_resp = AXI_RESP_SLVERR;
    end else if (s_axi_araddr[3:0] == TRANSCEIVER_CONTROL_REGISTER_OFS) begin
      rd_word[CTRL_ADDR_LSB +: 5] = ctrl_addr_ff;
    end else if (s_axi_araddr[3:0] == STRAP_STATUS_OFS) begin
      rd_word[STAT_ADDR_LSB +: 5] = strap_cfg_ff.addr;
      rd_word[STAT_ISOLATE_BIT] = isolate_ff;
      rd_word[STAT_NEG_EN_BIT] = strap_cfg_ff.neg_en;
      rd_word[STAT_CAP_LSB +: 2] = strap_cfg_ff.cap;
      rd_word[STAT_VALID_BIT] = valid_ff;
    end else begin
      rd_resp = AXI_RESP_SLVERR;
    end
  end

  // axi read: one outstanding read, data one cycle after the address is taken
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= AXI_RESP_OKAY;
    end else begin
      if (arready_ff && s_axi_arvalid) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_word;
        rresp_ff <= rd_resp;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  assign o_strap_pin_out = pin_out_ff;
  assign o_strap_pin_oe_n = pin_oe_n_ff;
  assign o_station_addr = ctrl_addr_ff;
  assign o_isolate = isolate_ff;
  assign o_negotiation_enable = neg_en_ff;
  assign o_advert = advert_ff;
  assign o_forced_speed_100 = forced_100_ff;
  assign o_forced_full_duplex = forced_full_ff;
  assign o_config_valid = valid_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // checks on the capture sequence and the chosen mode
  AST_LATCH_CAPTURES_PINS: assert property (@(posedge i_core_clk) disable iff (i_rst)
    latch_pulse |=> o_config_valid && strap_cfg_ff.addr == $past(pin_sync[4:0]))
    else $error("strap address not captured at latch");
  AST_PINS_RELEASED_SAMPLING: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_ff == ST_SAMPLE) |-> (o_strap_pin_oe_n == 8'hff) && !o_config_valid)
    else $error("strap pins driven while sampling");
  AST_PINS_DRIVEN_AFTER: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_config_valid ##1 o_config_valid |-> (o_strap_pin_oe_n == 8'h00) && (o_strap_pin_out == $past(i_func_pin_out)))
    else $error("strap pins not back in functional role");
  AST_ADDR_LOADED: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(o_config_valid) |-> o_station_addr == strap_cfg_ff.addr)
    else $error("control address differs from strapped address");
  AST_ADDR_ALL_ONES: assert property (@(posedge i_core_clk) disable iff (i_rst)
    latch_pulse && pin_sync[4:0] == 5'h1f |=> o_station_addr == 5'h1f && !o_isolate)
    else $error("address 31 not accepted");
  AST_ISOLATE_ON_ZERO: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(o_config_valid) |-> o_isolate == (strap_cfg_ff.addr == 5'h00))
    else $error("isolate does not match strapped zero");
  AST_ISOLATE_ONLY_AT_LATCH: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(o_isolate) |-> $past(latch_pulse))
    else $error("isolate entered outside strap latch");
  AST_NEG_ADVERT: assert property (@(posedge i_core_clk) disable iff (i_rst)
    latch_pulse && pin_sync[5] && pin_sync[7:6] == 2'b10 |=> o_negotiation_enable && o_advert == 4'hc)
    else $error("negotiation advertisement wrong");
  AST_FORCED_MODE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    latch_pulse && !pin_sync[5] |=> !o_negotiation_enable && o_forced_speed_100 == $past(pin_sync[6])
      && o_forced_full_duplex == $past(pin_sync[7]) && o_advert == 4'h0)
    else $error("forced speed or duplex wrong");

endmodule : strap_option_sampler

//--- board_strap_model.sv
// board side of the shared strap pins: fitted resistors, weak pulls and the device drive
`timescale 1ns/1ps
module board_strap_model
  import strap_pkg::*;
(
  input wire logic [7:0] i_ext_level, // level set by a fitted resistor
  input wire logic [7:0] i_ext_fitted, // one where a resistor is fitted
  input wire logic [7:0] i_pin_drive, // value the device drives
  input wire logic [7:0] i_pin_oe_n, // device drive enable, low drives
  output logic [7:0] o_pin_level // resolved wire level
);
  // the device drive wins over a fitted resistor, the resistor wins over the weak pull
  always_comb begin
    for (int b = 0; b < STRAP_PIN_COUNT; b++) begin
      if (!i_pin_oe_n[b]) begin
        o_pin_level[b] = i_pin_drive[b];
      end else if (i_ext_fitted[b]) begin
        o_pin_level[b] = i_ext_level[b];
      end else begin
        o_pin_level[b] = STRAP_PULL_DEFAULT[b]; // unfitted pins rest at the pull level
      end
    end
  end
endmodule : board_strap_model

//--- tb_strap_option_sampler.sv
// testbench: strap sampling, mode decode and register access for the strap option sampler
`timescale 1ns/1ps
module tb_strap_option_sampler
  import strap_pkg::*;
;
  logic i_core_clk = 1'b0, i_rst = 1'b1;
  logic [7:0] pin_lvl, ext_level = 8'h00, ext_fitted = 8'h00, i_func_pin_out = 8'h00;
  logic [7:0] o_strap_pin_out, o_strap_pin_oe_n;
  logic [4:0] o_station_addr;
  logic o_isolate, o_negotiation_enable, o_forced_speed_100, o_forced_full_duplex, o_config_valid;
  logic [3:0] o_advert;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int err_total = 0, n_tests = 0;
  logic [7:0] lvl_tab [9] = '{8'h00, 8'h00, 8'h9f, 8'h4a, 8'hd5, 8'h22, 8'ha4, 8'h68, 8'hf0};
  logic [7:0] fit_tab [9] = '{8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

  always #2.5 i_core_clk = ~i_core_clk;

  strap_option_sampler strap_option_sampler_i (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_strap_pin_in(pin_lvl), .i_func_pin_out(i_func_pin_out),
    .o_strap_pin_out(o_strap_pin_out), .o_strap_pin_oe_n(o_strap_pin_oe_n), .o_station_addr(o_station_addr),
    .o_isolate(o_isolate), .o_negotiation_enable(o_negotiation_enable), .o_advert(o_advert),
    .o_forced_speed_100(o_forced_speed_100), .o_forced_full_duplex(o_forced_full_duplex),
    .o_config_valid(o_config_valid), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  board_strap_model board_strap_model_i (
    .i_ext_level(ext_level), .i_ext_fitted(ext_fitted), .i_pin_drive(o_strap_pin_out),
    .i_pin_oe_n(o_strap_pin_oe_n), .o_pin_level(pin_lvl));

  // closing report, the single end of the run
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // a spent wait bound is a mismatch and ends the run at once
  task automatic timed_out();
    err_total++;
    $display("mismatch at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
    print_verdict();
  endtask : timed_out

  // write: address and data offered together, each released once taken
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge i_core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (k == 50) timed_out();
    r = bresp;
    bready <= 1'b0;
    // let an edge pass so a following call never sets bready twice in one step
    @(posedge i_core_clk);
  endtask : axi_write

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge i_core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (k == 50) timed_out();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // let an edge pass so a following call never sets rready twice in one step
    @(posedge i_core_clk);
  endtask : axi_read

  // one reset with a given strap setting, then every decoded output and register
  task automatic run_case(input int n);
    logic [7:0] s;
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] adv;
    int k;
    ext_level <= lvl_tab[n];
    ext_fitted <= fit_tab[n];
    i_func_pin_out <= ~lvl_tab[n];
    i_rst <= 1'b1;
    repeat (10) @(posedge i_core_clk);
    check(o_strap_pin_oe_n, 8'hff);
    check(o_config_valid, 1'b0);
    i_rst <= 1'b0;
    for (k = 0; k < 20 && o_config_valid !== 1'b1; k++) @(posedge i_core_clk);
    if (k == 20) timed_out();
    @(posedge i_core_clk);
    s = (lvl_tab[n] & fit_tab[n]) | (STRAP_PULL_DEFAULT & ~fit_tab[n]);
    case ({s[6], s[7]})
      2'b00: adv = ADV_10_HALF_FULL;
      2'b01: adv = ADV_100_HALF_FULL;
      2'b10: adv = ADV_10_HALF;
      default: adv = ADV_10_100_HALF;
    endcase
    check(o_station_addr, s[4:0]);
    check(o_isolate, s[4:0] == 5'h00);
    check(o_negotiation_enable, s[5]);
    check(o_advert, s[5] ? adv : 4'h0);
    check(o_forced_speed_100, !s[5] && s[6]);
    check(o_forced_full_duplex, !s[5] && s[7]);
    check(o_strap_pin_oe_n, 8'h00);
    check(o_config_valid, 1'b1);
    // cast keeps the inversion to the pin width before the value is widened
    check(pin_lvl, 8'(~lvl_tab[n]));
    axi_read({28'h0, STRAP_STATUS_OFS}, d, r);
    // status capability field is {high, low} at bits 8:7
    check(d, {22'h0, 1'b1, s[6], s[7], s[5], s[4:0] == 5'h00, s[4:0]});
    axi_read({28'h0, TRANSCEIVER_CONTROL_REGISTER_OFS}, d, r);
    check(d, {27'h0, s[4:0]});
    axi_write({28'h0, TRANSCEIVER_CONTROL_REGISTER_OFS}, 32'h0, r);
    check(r, AXI_RESP_OKAY);
    axi_read({28'h0, TRANSCEIVER_CONTROL_REGISTER_OFS}, d, r);
    check(d, 32'h0);
    check(o_isolate, s[4:0] == 5'h00);
    check(o_station_addr, 5'h00);
    axi_read(32'h8, d, r);
    check(d, 32'h0);
    check(r, AXI_RESP_SLVERR);
    $display("case %0d done", n);
  endtask : run_case

  initial begin
    for (int n = 0; n < 9; n++) begin
      run_case(n);
    end
    print_verdict();
  end
endmodule : tb_strap_option_sampler
